// ===== scsh_pkg.sv
// Constants shared by the serial control hub blocks
package scsh_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned SMB_DIV = 16;
  localparam logic [1:0] PHASE_LAST = 2'(SMB_DIV / 4 - 1);
  localparam logic [7:0] RESET_SEQ_CYCLES = 8'h40;
  // ----------------------------------------
  // Chain framing
  // ----------------------------------------
  localparam logic [3:0] RESET_PATTERN = 4'hc;
  localparam logic [2:0] START_PATTERN = 3'h2;
  localparam logic [5:0] FRAME_BITS = 6'h26;
  localparam logic [4:0] REPLY_BITS = 5'h10;
  localparam int FR_BC = 37;
  localparam int FR_CHIP = 32;
  localparam int FR_OP = 28;
  localparam int FR_ADDR = 16;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [3:0] OP_REG_READ = 4'h0;
  localparam logic [3:0] OP_REG_WRITE = 4'h1;
  localparam logic [3:0] OP_CHAIN_RESET = 4'h9;
  localparam logic [3:0] OP_EE_WRITE = 4'hd;
  localparam logic [3:0] OP_EE_READ = 4'he;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [11:0] OFS_CH_CTRL = 12'h002;
  localparam logic [11:0] OFS_EE_RESULT = 12'h010;
  localparam logic [11:0] OFS_CHIP_ID = 12'h011;
  localparam int CC_A_OFF = 0;
  localparam int CC_B_OFF = 1;
  localparam int CC_CLKGEN = 4;
  localparam int CC_INIT = 8;
  localparam logic [15:0] CH_CTRL_MASK = 16'h0013;
  localparam logic [15:0] CH_CTRL_RST = 16'h0000;
  localparam logic [4:0] CHIP_ID_RST = 5'h00;
  localparam int EE_VALID = 15;
  localparam int EE_DONE = 14;
endpackage

// ===== scsh_smb_if.sv
// Request and answer signals between the hub core and its SMBus engine
`timescale 1ns/1ps
interface scsh_smb_if;
  logic tick;
  logic start;
  logic is_read;
  logic [6:0] slave_addr;
  logic [7:0] byte_addr;
  logic [7:0] wr_data;
  logic busy;
  logic done;
  logic ok;
  logic [7:0] rd_data;
  modport core (output tick, start, is_read, slave_addr, byte_addr, wr_data,
    input busy, done, ok, rd_data);
  modport engine (input tick, start, is_read, slave_addr, byte_addr, wr_data,
    output busy, done, ok, rd_data);
endinterface

// ===== scsh_smb_engine.sv
// SMBus master for EEPROM byte write and random read
`timescale 1ns/1ps
module scsh_smb_engine #(
  parameter int unsigned TIMEOUT_CYCLES = scsh_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Core side
  scsh_smb_if.engine bus,
  // SMBus pins
  input wire logic smb_clk_in,
  output logic smb_clk_out,
  output logic smb_clk_oe_out,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe_out
);
  typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} scsh_eng_t;
  scsh_eng_t state;
  logic scl_s1, scl_s2, sda_s1, sda_s2;
  logic [1:0] pre, q, idx;
  logic [3:0] bitn;
  logic [7:0] sr;
  logic rd, scl_low, sda_low, step, stall;
  logic [31:0] tcnt;

  function automatic logic [7:0] tx_byte(input logic [1:0] i, input logic r,
      input logic [6:0] a, input logic [7:0] b, input logic [7:0] w);
    case (i)
      2'h0: tx_byte = {a, 1'b0};
      2'h1: tx_byte = b;
      2'h2: tx_byte = r ? {a, 1'b1} : w;
      default: tx_byte = 8'hff;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisers and clock division
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    scl_s1 <= smb_clk_in;
    scl_s2 <= scl_s1;
    sda_s1 <= smb_data_in;
    sda_s2 <= sda_s1;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || state == E_IDLE) begin
      pre <= 2'h0;
    end else if (bus.tick && !stall) begin
      pre <= pre + 2'h1;
    end
  end

  assign step = bus.tick && pre == scsh_pkg::PHASE_LAST && !stall;
  assign stall = (state == E_BIT || state == E_STOP) && q == 2'h2 && !scl_s2;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !stall) begin
      tcnt <= 32'h0;
    end else begin
      tcnt <= tcnt + 32'h1;
    end
  end

  // ----------------------------------------
  // Bit sequencer
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    bus.done <= 1'b0;
    if (sys_rst_in) begin
      state <= E_IDLE;
      q <= 2'h0;
      idx <= 2'h0;
      bitn <= 4'h0;
      sr <= 8'h00;
      rd <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      bus.ok <= 1'b0;
      bus.rd_data <= 8'h00;
    end else if (stall && tcnt == TIMEOUT_CYCLES - 1) begin
      state <= E_IDLE;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      bus.done <= 1'b1;
      bus.ok <= 1'b0;
    end else if (state == E_IDLE) begin
      q <= 2'h0;
      if (bus.start) begin
        state <= E_START;
        rd <= bus.is_read;
        idx <= 2'h0;
      end
    end else if (step) begin
      q <= q + 2'h1;
      case (state)
        E_START: begin
          case (q)
            2'h0: sda_low <= 1'b0;
            2'h1: scl_low <= 1'b0;
            2'h2: sda_low <= 1'b1;
            default: begin
              scl_low <= 1'b1;
              sr <= tx_byte(idx, rd, bus.slave_addr, bus.byte_addr, bus.wr_data);
              bitn <= 4'h0;
              state <= E_BIT;
            end
          endcase
        end
        E_BIT: begin
          case (q)
            2'h0: begin
              if (bitn == 4'h8) begin
                sda_low <= 1'b0;
              end else begin
                sda_low <= (idx == 2'h3) ? 1'b0 : !sr[7];
              end
            end
            2'h1: scl_low <= 1'b0;
            2'h2: begin
              if (bitn != 4'h8) begin
                sr <= {sr[6:0], sda_s2};
              end else if (idx != 2'h3 && sda_s2) begin
                state <= E_IDLE;
                scl_low <= 1'b0;
                sda_low <= 1'b0;
                bus.done <= 1'b1;
                bus.ok <= 1'b0;
              end
            end
            default: begin
              scl_low <= 1'b1;
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                sr <= tx_byte(idx + 2'h1, rd, bus.slave_addr, bus.byte_addr, bus.wr_data);
                idx <= idx + 2'h1;
                if (idx == 2'h3) begin
                  bus.rd_data <= sr;
                  state <= E_STOP;
                end else if (idx == 2'h1 && rd) begin
                  state <= E_START;
                end else if (idx == 2'h2 && !rd) begin
                  state <= E_STOP;
                end
              end
            end
          endcase
        end
        default: begin
          case (q)
            2'h0: sda_low <= 1'b1;
            2'h1: scl_low <= 1'b0;
            2'h2: sda_low <= 1'b1;
            default: begin
              sda_low <= 1'b0;
              state <= E_IDLE;
              bus.done <= 1'b1;
              bus.ok <= 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  assign bus.busy = state != E_IDLE;
  assign smb_clk_out = 1'b0;
  assign smb_clk_oe_out = scl_low;
  assign smb_data_out = 1'b0;
  assign smb_data_oe_out = sda_low;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  scl_divide_a: assert property (!bus.tick |=> $stable(scl_low))
    else $error("SMBus clock moved without a chain clock tick");
  timeout_abort_a: assert property (stall && tcnt == TIMEOUT_CYCLES - 1
    |=> bus.done && !bus.ok && !smb_clk_oe_out)
    else $error("Clock stretch timeout did not abandon transfer");
  nack_abort_a: assert property (step && state == E_BIT && q == 2'h2 && bitn == 4'h8
    && idx != 2'h3 && sda_s2 |=> bus.done && !bus.ok && !bus.busy)
    else $error("Missing acknowledge did not abandon transfer");
  cv_read_ok: cover property (bus.done && bus.ok && rd);
  cv_error: cover property (bus.done && !bus.ok);
endmodule

// ===== scsh_hub.sv
// Serial control chain front end of the memory hub with SPD access
// Contract
// - Sample command line on both clock edges
// - Pattern 1100 resets chain pin state
// - After reset: upstream input, downstream output, repeater
// - Broadcast chain reset drives channels A, B
// - Switched-off channel (off bit set) ignores broadcast initialisation; the init bit powers up every powered-down channel whose off bit is clear
// - Address field selects register or EEPROM slave
// - Data field: byte address, write data
// - Random read: address write, then read
// - Read byte stored, bit 15 valid
// - Reading result register clears bit 15
// - Successful byte write sets bit 14
// - Read frame uses repeated start and NACK
// - SMBus clock is chain clock over 16
// - NACK or stretch timeout aborts, sets bit 14
// - Timeout at least 25 ms after bit
// - Hard reset: defaults, channels and clocks down
// - Channel control bits switch off channels
// - Opcode 1110 starts EEPROM random read
// - Opcode 1101 starts EEPROM byte write
// - Opcode 1001 resets addressed hub channels
`timescale 1ns/1ps
module scsh_hub #(
  parameter int unsigned TIMEOUT_CYCLES = scsh_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Serial control chain
  input wire logic chain_serial_clock_in,
  input wire logic chain_command_line_in,
  input wire logic upstream_chain_pin_in,
  output logic upstream_chain_pin_out,
  output logic upstream_chain_pin_oe_out,
  input wire logic downstream_chain_pin_in,
  output logic downstream_chain_pin_out,
  output logic downstream_chain_pin_oe_out,
  output logic repeater_enable_out,
  // Downstream channels
  output logic chan_a_sio_reset_out,
  output logic chan_b_sio_reset_out,
  output logic chan_a_power_down_out,
  output logic chan_b_power_down_out,
  output logic clock_gen_enable_out,
  // SMBus pins
  input wire logic smb_clk_in,
  output logic smb_clk_out,
  output logic smb_clk_oe_out,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe_out
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  scsh_smb_if smb ();
  logic sck_s1, sck_s2, sck_d;
  logic cmd_s1, cmd_s2;
  logic up_s1, up_s2;
  logic rise, edge_any;
  logic [3:0] hist, next_hist;
  logic chain_rst;
  logic in_frame;
  logic [5:0] bit_cnt;
  logic [37:0] frame;
  logic frame_done;
  logic [3:0] op;
  logic [11:0] addr;
  logic [15:0] data;
  logic hit;
  logic [4:0] reply_cnt;
  logic [15:0] reply_sr;
  logic [15:0] ch_ctrl;
  logic [4:0] chip_id;
  logic a_pd, b_pd;
  logic ee_valid, ee_done;
  logic [7:0] ee_data;
  logic ee_read_acc;
  logic ee_cmd;
  logic [7:0] seq_cnt;
  logic [15:0] next_ch_ctrl;

  function automatic logic [15:0] reg_read(input logic [11:0] a,
      input logic [15:0] cc, input logic [4:0] id, input logic v,
      input logic d, input logic [7:0] ed);
    if (a == scsh_pkg::OFS_CH_CTRL) begin
      reg_read = cc;
    end else if (a == scsh_pkg::OFS_EE_RESULT) begin
      reg_read = {v, d, 6'h00, ed};
    end else if (a == scsh_pkg::OFS_CHIP_ID) begin
      reg_read = {11'h000, id};
    end else begin
      reg_read = 16'h0000;
    end
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    sck_s1 <= chain_serial_clock_in;
    sck_s2 <= sck_s1;
    sck_d <= sck_s2;
    cmd_s1 <= chain_command_line_in;
    cmd_s2 <= cmd_s1;
    up_s1 <= upstream_chain_pin_in;
    up_s2 <= up_s1;
  end

  assign rise = sck_s2 && !sck_d;
  assign edge_any = sck_s2 != sck_d;
  assign next_hist = {hist[2:0], cmd_s2};

  // ----------------------------------------
  // Command line history and chain reset
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hist <= 4'h0;
    end else if (edge_any) begin
      hist <= next_hist;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      chain_rst <= 1'b0;
    end else begin
      chain_rst <= edge_any && next_hist == scsh_pkg::RESET_PATTERN;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      upstream_chain_pin_oe_out <= 1'b0;
      downstream_chain_pin_oe_out <= 1'b0;
      repeater_enable_out <= 1'b0;
    end else if (chain_rst) begin
      upstream_chain_pin_oe_out <= 1'b0;
      downstream_chain_pin_oe_out <= 1'b1;
      repeater_enable_out <= 1'b1;
    end
  end

  assign upstream_chain_pin_out = 1'b0;

  // ----------------------------------------
  // Frame capture
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || chain_rst) begin
      in_frame <= 1'b0;
      bit_cnt <= 6'h00;
      frame <= 38'h0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (!in_frame && edge_any && next_hist[2:0] == scsh_pkg::START_PATTERN) begin
        in_frame <= 1'b1;
        bit_cnt <= 6'h00;
      end else if (in_frame && rise) begin
        frame <= {frame[36:0], up_s2};
        bit_cnt <= bit_cnt + 6'h01;
        if (bit_cnt == scsh_pkg::FRAME_BITS - 6'h01) begin
          in_frame <= 1'b0;
          frame_done <= 1'b1;
        end
      end
    end
  end

  assign op = frame[scsh_pkg::FR_OP +: 4];
  assign addr = frame[scsh_pkg::FR_ADDR +: 12];
  assign data = frame[15:0];
  assign hit = frame[scsh_pkg::FR_BC] || frame[scsh_pkg::FR_CHIP +: 5] == chip_id;
  assign ee_read_acc = frame_done && hit && op == scsh_pkg::OP_REG_READ
    && addr == scsh_pkg::OFS_EE_RESULT;
  assign ee_cmd = frame_done && hit && !smb.busy
    && (op == scsh_pkg::OP_EE_READ || op == scsh_pkg::OP_EE_WRITE);

  // ----------------------------------------
  // Read reply and repeating
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || chain_rst) begin
      reply_cnt <= 5'h00;
      reply_sr <= 16'h0000;
      downstream_chain_pin_out <= 1'b0;
    end else begin
      if (frame_done && hit && op == scsh_pkg::OP_REG_READ) begin
        reply_cnt <= scsh_pkg::REPLY_BITS;
        reply_sr <= reg_read(addr, ch_ctrl, chip_id, ee_valid, ee_done, ee_data);
      end else if (rise && reply_cnt != 5'h00) begin
        reply_cnt <= reply_cnt - 5'h01;
        reply_sr <= {reply_sr[14:0], 1'b0};
      end
      if (reply_cnt != 5'h00) begin
        downstream_chain_pin_out <= reply_sr[15];
      end else begin
        downstream_chain_pin_out <= repeater_enable_out && up_s2;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  assign next_ch_ctrl = data & scsh_pkg::CH_CTRL_MASK;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ch_ctrl <= scsh_pkg::CH_CTRL_RST;
      chip_id <= scsh_pkg::CHIP_ID_RST;
    end else if (frame_done && hit && op == scsh_pkg::OP_REG_WRITE) begin
      if (addr == scsh_pkg::OFS_CH_CTRL) begin
        ch_ctrl <= next_ch_ctrl;
      end else if (addr == scsh_pkg::OFS_CHIP_ID) begin
        chip_id <= data[4:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      a_pd <= 1'b1;
      b_pd <= 1'b1;
    end else if (frame_done && hit && op == scsh_pkg::OP_REG_WRITE
        && addr == scsh_pkg::OFS_CH_CTRL) begin
      a_pd <= next_ch_ctrl[scsh_pkg::CC_A_OFF] || (a_pd && !data[scsh_pkg::CC_INIT]);
      b_pd <= next_ch_ctrl[scsh_pkg::CC_B_OFF] || (b_pd && !data[scsh_pkg::CC_INIT]);
    end
  end

  assign chan_a_power_down_out = a_pd;
  assign chan_b_power_down_out = b_pd;
  assign clock_gen_enable_out = ch_ctrl[scsh_pkg::CC_CLKGEN];

  // ----------------------------------------
  // Downstream chain reset sequence
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      seq_cnt <= 8'h00;
    end else if (frame_done && hit && op == scsh_pkg::OP_CHAIN_RESET) begin
      seq_cnt <= scsh_pkg::RESET_SEQ_CYCLES;
    end else if (seq_cnt != 8'h00) begin
      seq_cnt <= seq_cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      chan_a_sio_reset_out <= 1'b0;
      chan_b_sio_reset_out <= 1'b0;
    end else begin
      chan_a_sio_reset_out <= seq_cnt != 8'h00 && !ch_ctrl[scsh_pkg::CC_A_OFF];
      chan_b_sio_reset_out <= seq_cnt != 8'h00 && !ch_ctrl[scsh_pkg::CC_B_OFF];
    end
  end

  // ----------------------------------------
  // EEPROM command launch
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      smb.start <= 1'b0;
      smb.is_read <= 1'b0;
      smb.slave_addr <= 7'h00;
      smb.byte_addr <= 8'h00;
      smb.wr_data <= 8'h00;
    end else begin
      smb.start <= ee_cmd;
      if (ee_cmd) begin
        smb.is_read <= op == scsh_pkg::OP_EE_READ;
        smb.slave_addr <= addr[6:0];
        smb.byte_addr <= data[7:0];
        smb.wr_data <= data[15:8];
      end
    end
  end

  assign smb.tick = rise;

  // ----------------------------------------
  // EEPROM result register
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ee_valid <= 1'b0;
      ee_done <= 1'b0;
      ee_data <= 8'h00;
    end else begin
      if (smb.done && smb.ok && smb.is_read) begin
        ee_valid <= 1'b1;
        ee_data <= smb.rd_data;
      end else if (ee_read_acc) begin
        ee_valid <= 1'b0;
      end
      if (smb.done && !(smb.ok && smb.is_read)) begin
        ee_done <= 1'b1;
      end else if (ee_cmd) begin
        ee_done <= 1'b0;
      end
    end
  end

  scsh_smb_engine #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) u_engine (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .bus(smb.engine),
    .smb_clk_in(smb_clk_in),
    .smb_clk_out(smb_clk_out),
    .smb_clk_oe_out(smb_clk_oe_out),
    .smb_data_in(smb_data_in),
    .smb_data_out(smb_data_out),
    .smb_data_oe_out(smb_data_oe_out)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  both_edge_a: assert property (edge_any |=> hist == {$past(hist[2:0]), $past(cmd_s2)})
    else $error("Command line not sampled on a clock edge");
  chain_reset_a: assert property (edge_any && next_hist == 4'hc
    |=> ##1 !in_frame && repeater_enable_out && downstream_chain_pin_oe_out
    && !upstream_chain_pin_oe_out)
    else $error("Chain reset pattern did not set pin directions");
  seq_start_a: assert property (frame_done && hit && op == 4'h9 && !ch_ctrl[0]
    |=> ##1 chan_a_sio_reset_out [*8])
    else $error("Channel reset sequence not driven");
  off_down_a: assert property (ch_ctrl[0] |-> chan_a_power_down_out
    && !chan_a_sio_reset_out)
    else $error("Switched off channel A is active");
  read_valid_a: assert property (smb.done && smb.ok && smb.is_read
    |=> ee_valid && ee_data == $past(smb.rd_data))
    else $error("EEPROM read data not posted");
  valid_clear_a: assert property (ee_read_acc && !smb.done |=> !ee_valid)
    else $error("Result read did not clear valid flag");
  write_done_a: assert property (smb.done && !smb.is_read |=> ee_done)
    else $error("Write completion flag not set");
  one_cmd_a: assert property (smb.busy |=> !smb.start)
    else $error("EEPROM command launched while busy");
  cv_chain_reset: cover property (chain_rst);
  cv_ee_read: cover property (ee_read_acc && ee_valid);
  cv_chan_reset: cover property (seq_cnt == scsh_pkg::RESET_SEQ_CYCLES);
endmodule

// ===== scsh_ctrl_model.sv
// Controller model driving the serial control chain
`timescale 1ns/1ps
module scsh_ctrl_model #(
  parameter int H = 5
) (
  // Clock
  input wire logic clk_in,
  // Chain pins
  output logic sck_out,
  output logic cmd_out,
  output logic sio_out,
  input wire logic reply_in,
  // Captured reply
  output logic rvalid_out,
  output logic [15:0] rdata_out
);
  initial begin
    sck_out = 1'b0;
    cmd_out = 1'b0;
    sio_out = 1'b0;
    rvalid_out = 1'b0;
    rdata_out = 16'h0000;
  end
  // One chain clock edge, pins set well ahead of it
  task automatic tick(input logic c, input logic d);
    @(negedge clk_in);
    cmd_out <= c;
    sio_out <= d;
    repeat (H) @(negedge clk_in);
    sck_out <= ~sck_out;
  endtask
  task automatic chain_reset();
    tick(1'b1, 1'b0);
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b1);
  endtask
  // Free clocking keeps the divided bus clock alive
  task automatic idle(input int n);
    repeat (2 * n) tick(1'b0, ~sio_out);
  endtask
  task automatic send(input logic [37:0] f, input logic rd);
    logic [15:0] r;
    r = 16'h0000;
    tick(1'b1, ~sio_out);
    tick(1'b0, ~sio_out);
    for (int i = 37; i >= 0; i--) begin
      tick(1'b0, f[i]);
      tick(1'b0, f[i]);
    end
    if (rd) begin
      for (int i = 0; i < 16; i++) begin
        r = {r[14:0], reply_in};
        tick(1'b0, ~sio_out);
        tick(1'b0, ~sio_out);
      end
      @(negedge clk_in);
      rdata_out <= r;
      rvalid_out <= 1'b1;
      @(negedge clk_in);
      rvalid_out <= 1'b0;
    end
  endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the serial control hub
`timescale 1ns/1ps
module testbench;
  localparam int H = 5;
  localparam int LOCK_WAIT = 250;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic ack_on = 1'b0;
  logic stretch = 1'b0;
  logic cnt_en = 1'b0;
  logic scl_q = 1'b0;
  logic sck, cl, sio, rv, uoe, dn, doe, rep, ra, rb, pa, pb, cg, coe, soe;
  logic [15:0] rdat;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h0ca72182;
  logic [27:0] mon = 28'h0;
  int err_total = 0;
  int cmp_count = 0;
  int na = 0;
  int nb = 0;
  int per = 0;
  int lastf = 0;
  wire scl = ~(coe | stretch);
  wire sda = ~(soe | ack_on);
  scsh_ctrl_model #(.H(H)) u_ctrl (.clk_in(clk_in), .sck_out(sck), .cmd_out(cl),
    .sio_out(sio), .reply_in(dn), .rvalid_out(rv), .rdata_out(rdat));
  scsh_hub #(.TIMEOUT_CYCLES(200)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .chain_serial_clock_in(sck), .chain_command_line_in(cl),
    .upstream_chain_pin_in(sio), .upstream_chain_pin_out(),
    .upstream_chain_pin_oe_out(uoe), .downstream_chain_pin_in(1'b0),
    .downstream_chain_pin_out(dn), .downstream_chain_pin_oe_out(doe),
    .repeater_enable_out(rep), .chan_a_sio_reset_out(ra), .chan_b_sio_reset_out(rb),
    .chan_a_power_down_out(pa), .chan_b_power_down_out(pb), .clock_gen_enable_out(cg),
    .smb_clk_in(scl), .smb_clk_out(), .smb_clk_oe_out(coe),
    .smb_data_in(sda), .smb_data_out(), .smb_data_oe_out(soe));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (90000) @(posedge clk_in);
    err_total++;
    results();
  end
  always @(posedge clk_in) begin
    scl_q <= coe;
    if (!coe && scl_q) begin
      mon <= {mon[26:0], ~soe};
    end
    lastf <= lastf + 1;
    if (coe && !scl_q) begin
      per <= lastf + 1;
      lastf <= 0;
    end
    if (cnt_en) begin
      na <= na + (ra === 1'b1);
      nb <= nb + (rb === 1'b1);
    end
    if (rv === 1'b1) begin
      chk("reply", rdat, exp_q.pop_front());
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic frame(input logic bc, input logic [4:0] ch, input logic [3:0] op,
      input logic [11:0] a, input logic [15:0] d);
    u_ctrl.send({bc, ch, op, a, d}, op == scsh_pkg::OP_REG_READ);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    frame(1'b0, 5'h00, scsh_pkg::OP_REG_READ, a, 16'h0000);
  endtask
  task automatic results();
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    logic [15:0] r;
    repeat (20) @(negedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    chk("pins", 16'({uoe, doe, rep, pa, pb, cg}), 16'h0006);
    u_ctrl.chain_reset();
    repeat (4) @(negedge clk_in);
    chk("dirs", 16'({uoe, doe, rep}), 16'h0003);
    frame(1'b0, 5'h00, scsh_pkg::OP_REG_WRITE, scsh_pkg::OFS_CHIP_ID, 16'h0000);
    rd(scsh_pkg::OFS_CH_CTRL, scsh_pkg::CH_CTRL_RST);
    rd(12'h3ff, 16'h0000);
    seed = lfsr(seed);
    r = seed[15:0] & 16'hfeff;
    frame(1'b0, 5'h00, scsh_pkg::OP_REG_WRITE, scsh_pkg::OFS_CH_CTRL, r);
    frame(1'b0, {seed[20:17], 1'b1}, scsh_pkg::OP_REG_WRITE, scsh_pkg::OFS_CH_CTRL, ~r);
    rd(scsh_pkg::OFS_CH_CTRL, r & scsh_pkg::CH_CTRL_MASK);
    frame(1'b0, 5'h00, scsh_pkg::OP_REG_WRITE, scsh_pkg::OFS_CH_CTRL, 16'h0010);
    repeat (LOCK_WAIT) @(negedge clk_in);
    for (int k = 0; k < 2; k++) begin
      frame(k == 0, k == 0 ? 5'h1f : 5'h00, scsh_pkg::OP_REG_WRITE, scsh_pkg::OFS_CH_CTRL,
        16'h0110 | 16'(k == 0));
      chk("power", 16'({pa, pb, cg}), k == 0 ? 16'h0005 : 16'h0001);
      na = 0;
      nb = 0;
      cnt_en = 1'b1;
      frame(k == 0, k == 0 ? 5'h1f : 5'h00, scsh_pkg::OP_CHAIN_RESET, 12'h000, 16'h0000);
      repeat (120) @(negedge clk_in);
      cnt_en = 1'b0;
      chk("reset a", 16'(na), k == 1 ? 16'(scsh_pkg::RESET_SEQ_CYCLES) : 16'h0000);
      chk("reset b", 16'(nb), 16'(scsh_pkg::RESET_SEQ_CYCLES));
    end
    for (int k = 0; k < 4; k++) begin
      ack_on <= (k != 2);
      stretch <= (k == 3);
      seed = lfsr(seed);
      frame(1'b0, 5'h00, k == 1 ? scsh_pkg::OP_EE_WRITE : scsh_pkg::OP_EE_READ, 12'h050,
        seed[15:0]);
      if (k == 1)
        frame(1'b0, 5'h00, scsh_pkg::OP_EE_READ, 12'h050, seed[31:16]);
      u_ctrl.idle(100);
      if (k == 0)
        chk("scl period", 16'(per), 16'(32 * (H + 1)));
      u_ctrl.idle(700);
      stretch <= 1'b0;
      if (k == 1) begin
        chk("smb write hi", {4'h0, mon[27:16]}, {4'h0, 7'h50, 2'h1, seed[7:5]});
        chk("smb write lo", mon[15:0], {seed[4:0], 1'b1, seed[15:8], 2'h2});
      end
      rd(scsh_pkg::OFS_EE_RESULT, k == 0 ? 16'h8000 : 16'h4000);
      if (k == 0)
        rd(scsh_pkg::OFS_EE_RESULT, 16'h0000);
    end
    repeat (10) @(negedge clk_in);
    results();
  end
endmodule
